// file: rtl/dma_chan_pkg.sv
// Purpose: Shared constants and types for the DMA channel request and address block
// Assumes: 32-bit AXI4-Lite register bus, 16-bit transfer buses
// Notes:   Register offsets are byte addresses, one aligned word each
package dma_chan_pkg;

  // Register map
  localparam int              REG_ADDR_W       = 8;
  localparam logic [7:0]      OFF_REQ_SELECT   = 8'h00;
  localparam logic [7:0]      OFF_PRIMARY      = 8'h04;
  localparam logic [7:0]      OFF_SECONDARY    = 8'h08;
  localparam logic [7:0]      OFF_PERIPH_ADDR  = 8'h0C;
  localparam logic [7:0]      OFF_CONTROL      = 8'h10;
  localparam logic [7:0]      OFF_COUNT        = 8'h14;
  localparam logic [7:0]      OFF_STATUS       = 8'h18;

  // Field positions
  localparam int              FORCE_BIT        = 15;
  localparam int              SRC_SEL_W        = 7;
  localparam int              CTRL_EN_BIT      = 15;
  localparam int              CTRL_BYTE_BIT    = 14;
  localparam int              CTRL_DIR_BIT     = 13;
  localparam int              COUNT_W          = 10;
  localparam int              STAT_BUFB_BIT    = 12;
  localparam int              STAT_BUSY_BIT    = 13;
  localparam int              STAT_EMPTY_BIT   = 14;

  // Values after reset
  localparam logic [15:0]     RST_REG16        = 16'h0000;
  localparam logic [6:0]      RST_SRC_SEL      = 7'h00;
  localparam logic [9:0]      RST_COUNT        = 10'h000;

  // Bus answers and sizes
  localparam logic [1:0]      RESP_OKAY        = 2'b00;
  localparam logic [1:0]      RESP_SLVERR      = 2'b10;
  localparam int              NUM_REQ_LINES    = 128;
  localparam int              XFER_FIFO_DEPTH  = 16;

  typedef enum logic [1:0] {
    MODE_CONT       = 2'b00,
    MODE_ONESHOT    = 2'b01,
    MODE_CONT_PP    = 2'b10,
    MODE_ONESHOT_PP = 2'b11
  } mode_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT  = 2'b10
  } eng_state_e;

  // Bus select, size and address of one access
  typedef struct packed {
    logic        ram_bus;
    logic        byte_size;
    logic [15:0] addr;
  } bus_addr_s;

  // One queued write: destination plus data
  typedef struct packed {
    logic        forced;
    bus_addr_s   dst;
    logic [15:0] data;
  } xfer_s;

endpackage

// file: rtl/dma_channel_request_and_address.sv
// Purpose: One DMA channel: request selection, buffer addressing, AXI4-Lite registers
// Assumes: Request lines and transfer buses are synchronous to mclk_in
// Notes:   Reads are queued into a FIFO before the destination write
// Overview of operation
// - Manual trigger performs exactly one transfer
// - Otherwise start only on selected request
// - Writing zero to manual trigger ignored
// - Hardware clears manual trigger after transfer
// - Seven-bit field picks one of 128 requests
// - Bits 14 to 7 read zero, unwritable
// - Primary RAM buffer start address register
// - Secondary RAM buffer start address register
// - Peripheral-side address register per transfer
// - One-shot ping-pong: one block per buffer
// - Continuous ping-pong alternates buffers forever
// - Block length is count plus one
`timescale 1ns/100ps

module xfer_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             arst_n_in,
  // Fill side
  input  wire logic             push_valid_in,
  output logic                  push_ready_out,
  input  wire logic [WIDTH-1:0] push_data_in,
  // Drain side
  output logic                  pop_valid_out,
  input  wire logic             pop_ready_in,
  output logic      [WIDTH-1:0] pop_data_out
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      fill;
  wire              do_push = push_valid_in & push_ready_out;
  wire              do_pop  = pop_valid_out & pop_ready_in;

  // Honest full and empty flags
  assign push_ready_out = (fill != (PW+1)'(DEPTH));
  assign pop_valid_out  = (fill != '0);
  assign pop_data_out   = mem[rd_ptr];

  // Storage array
  always_ff @(posedge mclk_in) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data_in;
    end
  end

  // Pointers and fill level
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (do_push) wr_ptr <= wr_ptr + 1'b1;
      if (do_pop)  rd_ptr <= rd_ptr + 1'b1;
      fill <= fill + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end
  end
endmodule

module dma_channel_request_and_address
  import dma_chan_pkg::*;
(
  // Clock and reset
  input  wire logic                     mclk_in,
  input  wire logic                     arst_n_in,
  // AXI4-Lite write channels
  input  wire logic [REG_ADDR_W-1:0]    s_axi_awaddr_in,
  input  wire logic                     s_axi_awvalid_in,
  output logic                          s_axi_awready_out,
  input  wire logic [31:0]              s_axi_wdata_in,
  input  wire logic [3:0]               s_axi_wstrb_in,
  input  wire logic                     s_axi_wvalid_in,
  output logic                          s_axi_wready_out,
  output logic [1:0]                    s_axi_bresp_out,
  output logic                          s_axi_bvalid_out,
  input  wire logic                     s_axi_bready_in,
  // AXI4-Lite read channels
  input  wire logic [REG_ADDR_W-1:0]    s_axi_araddr_in,
  input  wire logic                     s_axi_arvalid_in,
  output logic                          s_axi_arready_out,
  output logic [31:0]                   s_axi_rdata_out,
  output logic [1:0]                    s_axi_rresp_out,
  output logic                          s_axi_rvalid_out,
  input  wire logic                     s_axi_rready_in,
  // Peripheral requests
  input  wire logic [NUM_REQ_LINES-1:0] peripheral_request_lines_in,
  output logic                          channel_transfer_request_out,
  output logic                          channel_enabled_out,
  // Source read port
  output logic                          rd_valid_out,
  input  wire logic                     rd_ready_in,
  output bus_addr_s                     rd_req_out,
  input  wire logic [15:0]              rd_data_in,
  input  wire logic                     rd_data_valid_in,
  // Destination write port
  output logic                          wr_valid_out,
  input  wire logic                     wr_ready_in,
  output bus_addr_s                     wr_req_out,
  output logic [15:0]                   wr_data_out
);

  // Register state
  logic                 force_bit;
  logic [SRC_SEL_W-1:0] request_source_select;
  logic [15:0]          primary_buffer_start_field;
  logic [15:0]          secondary_buffer_start_field;
  logic [15:0]          peripheral_side_address;
  logic                 chan_enable;
  logic                 byte_size;
  logic                 dir_ram_to_periph;
  mode_e                chan_mode;
  logic [COUNT_W-1:0]   block_transfer_count;
  // Engine state
  eng_state_e           state;
  eng_state_e           next_state;
  logic [COUNT_W-1:0]   xfer_idx;
  logic                 buf_b;
  logic                 force_active;
  logic                 req_prev;
  logic                 req_pend;
  // Bus slave state
  logic                 aw_held;
  logic                 w_held;
  logic [REG_ADDR_W-1:0] aw_addr;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 rd_was_req;

  // Write decode
  wire do_write   = aw_held & w_held & ~s_axi_bvalid_out;
  wire wr_req_sel = do_write & (aw_addr == OFF_REQ_SELECT);
  wire wr_prim    = do_write & (aw_addr == OFF_PRIMARY);
  wire wr_sec     = do_write & (aw_addr == OFF_SECONDARY);
  wire wr_pad     = do_write & (aw_addr == OFF_PERIPH_ADDR);
  wire wr_ctrl    = do_write & (aw_addr == OFF_CONTROL);
  wire wr_cnt     = do_write & (aw_addr == OFF_COUNT);
  wire wr_stat    = do_write & (aw_addr == OFF_STATUS);
  wire wr_mapped  = wr_req_sel | wr_prim | wr_sec | wr_pad | wr_ctrl | wr_cnt | wr_stat;
  wire sw_set_force = wr_req_sel & w_strb[1] & w_data[FORCE_BIT];
  wire sw_set_en    = wr_ctrl & w_strb[1] & w_data[CTRL_EN_BIT];

  // Merge a 16-bit register with strobed write data
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Request selection and edge capture
  assign channel_transfer_request_out = peripheral_request_lines_in[request_source_select];
  wire   req_edge = channel_transfer_request_out & ~req_prev;

  // Engine decode
  xfer_s     push_entry;
  xfer_s     pop_entry;
  logic      fifo_ready;
  logic      fifo_valid;
  wire       is_pp       = chan_mode[1];
  wire       is_oneshot  = chan_mode[0];
  wire       start_force = chan_enable & force_bit & ~force_active;
  wire       start_req   = chan_enable & ~force_bit & req_pend;
  wire       start       = (state == ST_IDLE) & fifo_ready & (start_force | start_req);
  wire       push        = (state == ST_WAIT) & rd_data_valid_in;
  wire       last_xfer   = (xfer_idx == block_transfer_count);
  wire       hw_disable  = push & last_xfer & is_oneshot & (~is_pp | buf_b);
  wire       forced_done = wr_valid_out & wr_ready_in & pop_entry.forced;
  wire [15:0] ram_base   = buf_b ? secondary_buffer_start_field : primary_buffer_start_field;
  wire [15:0] ram_off    = byte_size ? {6'h00, xfer_idx} : {5'h00, xfer_idx, 1'b0};
  wire [15:0] ram_addr   = ram_base + ram_off;
  bus_addr_s ram_side;
  bus_addr_s periph_side;
  logic      cur_forced;

  // Same addressing for forced and requested transfers
  assign ram_side    = '{ram_bus: 1'b1, byte_size: byte_size, addr: ram_addr};
  assign periph_side = '{ram_bus: 1'b0, byte_size: byte_size, addr: peripheral_side_address};
  assign rd_req_out  = dir_ram_to_periph ? ram_side : periph_side;
  assign rd_valid_out = (state == ST_ISSUE);
  assign push_entry  = '{forced: cur_forced, dst: (dir_ram_to_periph ? periph_side : ram_side), data: rd_data_in};
  assign channel_enabled_out = chan_enable;

  // Engine next state
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:  if (start) next_state = ST_ISSUE;
      ST_ISSUE: if (rd_ready_in) next_state = ST_WAIT;
      ST_WAIT:  if (rd_data_valid_in) next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  // Engine registers
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state        <= ST_IDLE;
      xfer_idx     <= RST_COUNT;
      buf_b        <= 1'b0;
      force_active <= 1'b0;
      cur_forced   <= 1'b0;
      req_prev     <= 1'b0;
      req_pend     <= 1'b0;
    end else begin
      state    <= next_state;
      req_prev <= channel_transfer_request_out;
      if (req_edge) req_pend <= 1'b1;
      else if (start_req & start) req_pend <= 1'b0;
      if (start) cur_forced <= start_force;
      if (start & start_force) force_active <= 1'b1;
      else if (forced_done) force_active <= 1'b0;
      if (push) begin
        xfer_idx <= last_xfer ? RST_COUNT : xfer_idx + 1'b1;
        if (last_xfer & is_pp) buf_b <= ~buf_b;
      end
      if (wr_ctrl & ~chan_enable & sw_set_en) begin
        xfer_idx <= RST_COUNT;
        buf_b    <= 1'b0;
      end
    end
  end

  // Queue between read and write sides
  xfer_fifo #(
    .WIDTH ($bits(xfer_s)),
    .DEPTH (XFER_FIFO_DEPTH)
  ) u_fifo (
    .mclk_in        (mclk_in),
    .arst_n_in      (arst_n_in),
    .push_valid_in  (push),
    .push_ready_out (fifo_ready),
    .push_data_in   (push_entry),
    .pop_valid_out  (fifo_valid),
    .pop_ready_in   (wr_ready_in),
    .pop_data_out   (pop_entry)
  );

  assign wr_valid_out = fifo_valid;
  assign wr_req_out   = pop_entry.dst;
  assign wr_data_out  = pop_entry.data;

  // Software registers
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      force_bit                    <= 1'b0;
      request_source_select        <= RST_SRC_SEL;
      primary_buffer_start_field   <= RST_REG16;
      secondary_buffer_start_field <= RST_REG16;
      peripheral_side_address      <= RST_REG16;
      chan_enable                  <= 1'b0;
      byte_size                    <= 1'b0;
      dir_ram_to_periph            <= 1'b0;
      chan_mode                    <= MODE_CONT;
      block_transfer_count         <= RST_COUNT;
    end else begin
      // Set wins over the hardware clear; a written zero does nothing
      if (sw_set_force) force_bit <= 1'b1;
      else if (forced_done) force_bit <= 1'b0;
      if (wr_req_sel & w_strb[0]) request_source_select <= w_data[SRC_SEL_W-1:0];
      if (wr_prim) primary_buffer_start_field <= merge16(primary_buffer_start_field, w_data, w_strb);
      if (wr_sec)  secondary_buffer_start_field <= merge16(secondary_buffer_start_field, w_data, w_strb);
      if (wr_pad)  peripheral_side_address <= merge16(peripheral_side_address, w_data, w_strb);
      if (sw_set_en) chan_enable <= 1'b1;
      else if (hw_disable | (wr_ctrl & w_strb[1])) chan_enable <= 1'b0;
      if (wr_ctrl & w_strb[1]) begin
        byte_size         <= w_data[CTRL_BYTE_BIT];
        dir_ram_to_periph <= w_data[CTRL_DIR_BIT];
      end
      if (wr_ctrl & w_strb[0]) chan_mode <= mode_e'(w_data[1:0]);
      if (wr_cnt) block_transfer_count <= {w_strb[1] ? w_data[9:8] : block_transfer_count[9:8],
                                           w_strb[0] ? w_data[7:0] : block_transfer_count[7:0]};
    end
  end

  // Write channel handshakes
  assign s_axi_awready_out = ~aw_held & ~s_axi_bvalid_out;
  assign s_axi_wready_out  = ~w_held & ~s_axi_bvalid_out;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aw_held          <= 1'b0;
      w_held           <= 1'b0;
      aw_addr          <= '0;
      w_data           <= '0;
      w_strb           <= '0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in & s_axi_awready_out) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in & s_axi_wready_out) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      if (do_write) begin
        aw_held          <= 1'b0;
        w_held           <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // Read decode and data mux
  wire [15:0] stat_word = {1'b0, ~fifo_valid, (state != ST_IDLE), buf_b, 2'b00, xfer_idx};
  wire [15:0] ctrl_word = {chan_enable, byte_size, dir_ram_to_periph, 11'h000, chan_mode};
  wire        ar_take   = s_axi_arvalid_in & s_axi_arready_out;
  wire        rs_req    = (s_axi_araddr_in == OFF_REQ_SELECT);
  wire        rs_prim   = (s_axi_araddr_in == OFF_PRIMARY);
  wire        rs_sec    = (s_axi_araddr_in == OFF_SECONDARY);
  wire        rs_pad    = (s_axi_araddr_in == OFF_PERIPH_ADDR);
  wire        rs_ctrl   = (s_axi_araddr_in == OFF_CONTROL);
  wire        rs_cnt    = (s_axi_araddr_in == OFF_COUNT);
  wire        rs_stat   = (s_axi_araddr_in == OFF_STATUS);
  wire        rs_hit    = rs_req | rs_prim | rs_sec | rs_pad | rs_ctrl | rs_cnt | rs_stat;
  wire [15:0] rd_mux    = rs_req  ? {force_bit, 8'h00, request_source_select} :
                          rs_prim ? primary_buffer_start_field :
                          rs_sec  ? secondary_buffer_start_field :
                          rs_pad  ? peripheral_side_address :
                          rs_ctrl ? ctrl_word :
                          rs_cnt  ? {6'h00, block_transfer_count} :
                          rs_stat ? stat_word : 16'h0000;
  assign s_axi_arready_out = ~s_axi_rvalid_out;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= RESP_OKAY;
      rd_was_req       <= 1'b0;
    end else if (ar_take) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= {16'h0000, rd_mux};
      s_axi_rresp_out  <= rs_hit ? RESP_OKAY : RESP_SLVERR;
      rd_was_req       <= rs_req;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // Checks on the channel logic
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  a_force_clears_done: assert property (forced_done && !sw_set_force |=> !force_bit)
    else $error("manual trigger not cleared after forced write");
  a_force_no_sw_clr: assert property (force_bit && !forced_done |=> force_bit)
    else $error("manual trigger dropped without forced write");
  a_force_one_xfer: assert property (start && start_force |=> force_active && !start_force)
    else $error("second forced transfer started");
  a_req_gated_start: assert property (start && !force_bit |-> req_pend)
    else $error("transfer started without selected request");
  a_sel_reserved_zero: assert property (s_axi_rvalid_out && rd_was_req |-> s_axi_rdata_out[14:7] == 8'h00)
    else $error("reserved select bits read nonzero");
  a_primary_stable: assert property (!wr_prim |=> $stable(primary_buffer_start_field))
    else $error("primary start changed without write");
  a_periph_read_addr: assert property (rd_valid_out && !dir_ram_to_periph |-> rd_req_out.addr == peripheral_side_address)
    else $error("peripheral read address wrong");
  a_block_wraps: assert property (push && last_xfer |=> xfer_idx == 10'h000)
    else $error("transfer index did not wrap at block end");
  a_pingpong_flip: assert property (push && last_xfer && is_pp |=> buf_b != $past(buf_b))
    else $error("ping-pong buffer did not alternate");
  a_oneshot_stops: assert property (push && last_xfer && chan_mode == MODE_ONESHOT_PP && buf_b && !sw_set_en
                                    |=> !chan_enable)
    else $error("one-shot ping-pong did not stop after second buffer");
  a_bvalid_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write response dropped before ready");

  c_forced_xfer: cover property (start && start_force ##[1:40] forced_done);
  c_req_xfer: cover property (req_edge ##[1:20] push);
  c_pp_flip: cover property (push && last_xfer && is_pp);
  c_fifo_full: cover property (!fifo_ready);

endmodule

// file: verif/dma_channel_request_and_address_tb_top.sv
// Purpose: Register and transfer tests of one DMA channel
// Assumes: Partner returns address xor 5A5A
// Notes:   Peripheral address 0300, so peripheral reads give 595A
`timescale 1ns/100ps
module dma_channel_request_and_address_tb_top
  import dma_chan_pkg::*;
;
  logic        mclk_in, arst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  logic        s_axi_arvalid_in, s_axi_rready_in, s_axi_awready_out, s_axi_wready_out;
  logic        s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, rd_stall, wr_stall;
  logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rv;
  logic [3:0]  s_axi_wstrb_in;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, rr;
  logic [127:0] peripheral_request_lines_in;
  logic        channel_transfer_request_out, channel_enabled_out, rd_valid_out, rd_ready_in;
  logic        rd_data_valid_in, wr_valid_out, wr_ready_in;
  bus_addr_s   rd_req_out, wr_req_out, wr_last;
  logic [15:0] rd_data_in, wr_data_out, wr_dlast;
  int          rd_cnt, wr_cnt, mismatches, cmp_count, base, rbase;
  int          cyc = 0;
  int          lines[4] = '{0, 1, 77, 127};

  dma_channel_request_and_address u_dut (.*);
  xfer_partner u_far (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .rd_stall_in(rd_stall),
    .wr_stall_in(wr_stall), .rd_valid_in(rd_valid_out), .rd_ready_out(rd_ready_in),
    .rd_req_in(rd_req_out), .rd_data_out(rd_data_in), .rd_data_valid_out(rd_data_valid_in),
    .wr_valid_in(wr_valid_out), .wr_ready_out(wr_ready_in), .wr_req_in(wr_req_out),
    .wr_data_in(wr_data_out), .rd_count_out(rd_cnt), .wr_count_out(wr_cnt),
    .wr_last_out(wr_last), .wr_data_last_out(wr_dlast));

  // Clock
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  // Hang guard
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic do_reset();
    arst_n_in <= 1'b0;
    repeat (12) @(posedge mclk_in);
    arst_n_in <= 1'b1;
  endtask

  // Bus write: address and data offered together, released as taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    s_axi_awaddr_in  <= a;
    s_axi_wdata_in   <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in  <= 1'b1;
    s_axi_bready_in  <= 1'b1;
    do begin
      @(posedge mclk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (!s_axi_bvalid_out);
    rr = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk_in);
    s_axi_araddr_in  <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in  <= 1'b1;
    do begin
      @(posedge mclk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (!s_axi_rvalid_out);
    rv = s_axi_rdata_out;
    rr = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask

  task automatic pulse(input int n);
    peripheral_request_lines_in[n] <= 1'b1;
    @(posedge mclk_in);
    peripheral_request_lines_in[n] <= 1'b0;
  endtask

  // Wait for the next write, releasing any read stall on the way
  task automatic wait_chk(input logic [17:0] a, input logic [15:0] d);
    for (int k = 0; k < 50 && wr_cnt == base; k++) begin
      @(posedge mclk_in);
      if (k == 8) rd_stall <= 1'b0;
    end
    chk(wr_last, a);
    chk(wr_dlast, d);
  endtask

  task automatic xfer(input logic [15:0] a);
    base = wr_cnt;
    pulse(5);
    wait_chk({2'b10, a}, 16'h595A);
  endtask

  initial begin
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
    s_axi_wstrb_in = 4'hF;
    peripheral_request_lines_in = '0;
    {rd_stall, wr_stall} = '0;
    arst_n_in = 1'b0;
    do_reset();
    foreach (lines[i]) begin
      wr(OFF_REQ_SELECT, 32'(lines[i]));
      peripheral_request_lines_in <= 128'(1) << lines[i];
      @(posedge mclk_in);
      chk(channel_transfer_request_out, 1'b1);
      peripheral_request_lines_in <= ~(128'(1) << lines[i]);
      @(posedge mclk_in);
      chk(channel_transfer_request_out, 1'b0);
    end
    peripheral_request_lines_in <= '0;
    do_reset();
    for (int i = 0; i < 4; i++) begin
      rd(8'(4 * i));
      chk(rv, 32'h0);
    end
    $display("test routing and reset done");
    wr(OFF_PRIMARY, 32'h1000);
    wr(OFF_SECONDARY, 32'h2000);
    wr(OFF_PERIPH_ADDR, 32'h0300);
    rd(OFF_PRIMARY);
    chk(rv, 32'h1000);
    rd(OFF_SECONDARY);
    chk(rv, 32'h2000);
    rd(OFF_PERIPH_ADDR);
    chk(rv, 32'h0300);
    wr(OFF_REQ_SELECT, 32'hFFFF7FFF);
    rd(OFF_REQ_SELECT);
    chk(rv, 32'h007F);
    wr(8'h1C, 32'h1);
    chk(rr, RESP_SLVERR);
    rd(8'h1C);
    chk(rr, RESP_SLVERR);
    chk(rv, 32'h0);
    $display("test registers done");
    wr(OFF_REQ_SELECT, 32'h5);
    wr(OFF_COUNT, 32'h1);
    wr(OFF_CONTROL, 32'h8001);
    base = wr_cnt;
    pulse(6);
    repeat (20) @(posedge mclk_in);
    chk(wr_cnt, base);
    rd_stall <= 1'b1;
    xfer(16'h1000);
    xfer(16'h1002);
    chk(channel_enabled_out, 1'b0);
    wr(OFF_COUNT, 32'h0);
    wr(OFF_CONTROL, 32'h8003);
    xfer(16'h1000);
    xfer(16'h2000);
    chk(channel_enabled_out, 1'b0);
    wr(OFF_CONTROL, 32'h8002);
    xfer(16'h1000);
    xfer(16'h2000);
    xfer(16'h1000);
    chk(channel_enabled_out, 1'b1);
    wr(OFF_CONTROL, 32'h0002);
    $display("test blocks done");
    wr(OFF_COUNT, 32'h1);
    wr(OFF_REQ_SELECT, 32'h8005);
    wr(OFF_REQ_SELECT, 32'h0005);
    rd(OFF_REQ_SELECT);
    chk(rv, 32'h8005);
    base = wr_cnt;
    wr(OFF_CONTROL, 32'h8001);
    wait_chk({2'b10, 16'h1000}, 16'h595A);
    repeat (20) @(posedge mclk_in);
    chk(wr_cnt, base + 1);
    rd(OFF_REQ_SELECT);
    chk(rv, 32'h0005);
    xfer(16'h1002);
    chk(channel_enabled_out, 1'b0);
    $display("test forced transfer done");
    wr(OFF_CONTROL, 32'hE001);
    for (int i = 0; i < 2; i++) begin
      base = wr_cnt;
      pulse(5);
      wait_chk({2'b01, 16'h0300}, 16'h4A5A + 16'(i));
    end
    chk(channel_enabled_out, 1'b0);
    $display("test byte ram to peripheral done");
    wr_stall <= 1'b1;
    wr(OFF_COUNT, 32'h1F);
    wr(OFF_CONTROL, 32'h8000);
    base = wr_cnt;
    rbase = rd_cnt;
    repeat (20) begin
      pulse(5);
      repeat (8) @(posedge mclk_in);
    end
    chk(rd_cnt - rbase, XFER_FIFO_DEPTH);
    rd(OFF_STATUS);
    chk(rv[STAT_EMPTY_BIT], 1'b0);
    wr_stall <= 1'b0;
    for (int k = 0; k < 300 && wr_cnt - base < 17; k++) @(posedge mclk_in);
    chk(wr_cnt - base, 17);
    rd(OFF_STATUS);
    chk(rv[STAT_EMPTY_BIT], 1'b1);
    wr(OFF_CONTROL, 32'h0);
    $display("test buffer done");
    finish_test();
  end
endmodule

// file: verif/xfer_partner.sv
// Purpose: Far-side model of the peripheral and RAM buses
// Assumes: Same clock as the channel
// Notes:   Read data is the address xor 5A5A; stalls hold off handshakes
`timescale 1ns/100ps
module xfer_partner
  import dma_chan_pkg::*;
(
  // Clock, reset, stalls
  input  wire logic        mclk_in,
  input  wire logic        arst_n_in,
  input  wire logic        rd_stall_in,
  input  wire logic        wr_stall_in,
  // Read port
  input  wire logic        rd_valid_in,
  output logic             rd_ready_out,
  input  wire bus_addr_s   rd_req_in,
  output logic [15:0]      rd_data_out,
  output logic             rd_data_valid_out,
  // Write port and record
  input  wire logic        wr_valid_in,
  output logic             wr_ready_out,
  input  wire bus_addr_s   wr_req_in,
  input  wire logic [15:0] wr_data_in,
  output int               rd_count_out,
  output int               wr_count_out,
  output bus_addr_s        wr_last_out,
  output logic [15:0]      wr_data_last_out
);
  logic        pend;
  logic [15:0] pend_addr;

  // One read at a time, writes unless stalled
  assign rd_ready_out = !rd_stall_in && !pend;
  assign wr_ready_out = !wr_stall_in;

  // Data toggles while idle so stale values never match
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pend              <= 1'b0;
      pend_addr         <= 16'h0000;
      rd_data_out       <= 16'h0000;
      rd_data_valid_out <= 1'b0;
      rd_count_out      <= 0;
      wr_count_out      <= 0;
      wr_last_out       <= '0;
      wr_data_last_out  <= 16'h0000;
    end else begin
      rd_data_valid_out <= 1'b0;
      rd_data_out       <= ~rd_data_out;
      if (rd_valid_in && rd_ready_out) begin
        pend         <= 1'b1;
        pend_addr    <= rd_req_in.addr;
        rd_count_out <= rd_count_out + 1;
      end else if (pend && !rd_stall_in) begin
        pend              <= 1'b0;
        rd_data_valid_out <= 1'b1;
        rd_data_out       <= pend_addr ^ 16'h5A5A;
      end
      if (wr_valid_in && wr_ready_out) begin
        wr_count_out     <= wr_count_out + 1;
        wr_last_out      <= wr_req_in;
        wr_data_last_out <= wr_data_in;
      end
    end
  end
endmodule
